/* File: dv/seu_hardened_config_and_fsm_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module seu_hardened_config_and_fsm_monitor (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       line_encoding_strap,
  input wire logic       driver_select_strap,
  input wire logic       rate_width_select_strap,
  input wire logic       cfgWrEn,
  input wire logic [7:0] cfgWrData,
  input wire logic       lineEncoding,
  input wire logic       driverSelect,
  input wire logic       slowMode,
  input wire logic [7:0] preBias,
  input wire logic       scrubActive,
  input wire logic [1:0] ctlState,
  input wire logic       copiesDisagree
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // strap flops hold reset zeros for the first edges after release
  sequence settled;
    !$past(sys_rst) && !$past(sys_rst, 2) && !$past(sys_rst, 3);
  endsequence
  AST_STRAP_ENC: assert property (
    settled |-> lineEncoding == $past(line_encoding_strap, 2)) else $error("encoding lag");
  AST_STRAP_DRV: assert property (
    settled |-> driverSelect == $past(driver_select_strap, 2)) else $error("driver lag");
  AST_STRAP_RATE: assert property (
    settled |-> slowMode == $past(rate_width_select_strap, 2)) else $error("rate lag");
  AST_BIAS_WR: assert property (
    cfgWrEn |-> ##2 preBias == $past(cfgWrData, 2)) else $error("bias write lost");
  AST_BIAS_HOLD: assert property (
    $changed(preBias) && !$past(sys_rst) |-> $past(cfgWrEn, 2)) else $error("bias moved without write");
  AST_SCRUB_PULSE: assert property (
    scrubActive |=> !scrubActive) else $error("scrub pulse too long");
  AST_STATE_ORDER: assert property (
    $changed(ctlState) && !$past(sys_rst) |-> ctlState == $past(ctlState) + 2'h1)
    else $error("state skipped");
  AST_RECOVER: assert property (
    copiesDisagree |-> ##[1:3] !copiesDisagree) else $error("copies stay split");
  AST_RESET: assert property (disable iff (1'b0)
    sys_rst |=> ctlState == 2'h0 && !scrubActive && !copiesDisagree && preBias == 8'h00)
    else $error("reset state wrong");
  COV_SCRUB: cover property (scrubActive);
  COV_SPLIT: cover property (copiesDisagree);
  COV_HOLD: cover property (ctlState == 2'h3);
endmodule // seu_hardened_config_and_fsm_monitor
bind seu_hardened_config_and_fsm seu_hardened_config_and_fsm_monitor mon_i (
  .clk, .sys_rst, .line_encoding_strap, .driver_select_strap, .rate_width_select_strap,
  .cfgWrEn, .cfgWrData, .lineEncoding, .driverSelect, .slowMode, .preBias,
  .scrubActive, .ctlState, .copiesDisagree
);
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        encS = 1'b0, drvS = 1'b0, rateS = 1'b0;
  logic        cfgWrEn = 1'b0, startReq = 1'b0, stopReq = 1'b0;
  logic [7:0]  cfgWrData = 8'h00;
  logic [11:0] upsetMask = 12'h000;
  logic [1:0]  stateUpset = 2'h0;
  logic        lineEncoding, driverSelect, slowMode, scrubActive, copiesDisagree;
  logic [7:0]  preBias;
  logic [1:0]  ctlState;
  int          mismatches = 0, samples_checked = 0;
  always #25 clk = ~clk;
  seu_hardened_config_and_fsm seu_hardened_config_and_fsm_i (
    .clk, .sys_rst, .line_encoding_strap(encS), .driver_select_strap(drvS),
    .rate_width_select_strap(rateS), .cfgWrEn, .cfgWrData, .startReq, .stopReq,
    .upsetMask, .stateUpset, .lineEncoding, .driverSelect, .slowMode, .preBias,
    .scrubActive, .ctlState, .copiesDisagree
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic close_out;
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic t_straps;
    for (int i = 0; i < 8; i++) begin
      {encS, drvS, rateS} = i[2:0];
      cyc(3);
      chk({5'h00, lineEncoding, driverSelect, slowMode}, {5'h00, i[2:0]});
    end
  endtask
  task automatic t_write(input logic [7:0] d);
    cfgWrEn = 1'b1;
    cfgWrData = d;
    cyc(1);
    cfgWrEn = 1'b0;
    cyc(2);
    chk(preBias, d);
  endtask
  // every single-bit flip, parity positions too, must be scrubbed exactly once
  task automatic t_scrub;
    int seen;
    for (int b = 0; b < 12; b++) begin
      seen = 0;
      upsetMask = 12'h001 << b;
      cyc(1);
      upsetMask = 12'h000;
      // the scrub pulse is already up at the first falling edge after the strike
      repeat (6) begin
        if (scrubActive === 1'b1) seen++;
        chk(preBias, 8'h5A);
        cyc(1);
      end
      chk(seen[7:0], 8'h01);
    end
  endtask
  task automatic wait_state(input logic [1:0] s);
    int n;
    n = 0;
    while (ctlState !== s && n < 20) begin
      cyc(1);
      n++;
    end
    chk({6'h00, ctlState}, {6'h00, s});
  endtask
  task automatic t_fsm;
    int split;
    split = 0;
    startReq = 1'b1;
    wait_state(seu_pkg::ST_RUN);
    for (int u = 1; u < 4; u++) begin
      split = 0;
      stateUpset = u[1:0];
      cyc(1);
      stateUpset = 2'h0;
      repeat (seu_pkg::RECOVER_CYCLES + 1) begin
        cyc(1);
        if (copiesDisagree === 1'b1) split++;
        chk({6'h00, ctlState}, 8'h02);
      end
      chk({7'h00, copiesDisagree}, 8'h00);
      chk({7'h00, split != 0 && split <= seu_pkg::RECOVER_CYCLES}, 8'h01);
    end
    startReq = 1'b0;
    stopReq = 1'b1;
    wait_state(seu_pkg::ST_IDLE);
    stopReq = 1'b0;
  endtask
  task automatic t_reset;
    startReq = 1'b1;
    wait_state(seu_pkg::ST_RUN);
    sys_rst = 1'b1;
    startReq = 1'b0;
    cyc(1);
    sys_rst = 1'b0;
    chk({6'h00, ctlState}, 8'h00);
    chk(preBias, 8'h00);
  endtask
  initial begin
    cyc(3);
    sys_rst = 1'b0;
    t_straps();
    t_write(8'hA5);
    t_write(8'h5A);
    t_scrub();
    t_fsm();
    t_reset();
    close_out();
  end
  // whole sequence needs under 200 cycles
  initial begin
    #(800 * seu_pkg::CLK_PERIOD_NS);
    mismatches++;
    close_out();
  end
endmodule // tb_top
`default_nettype wire

/* File: inc/seu_pkg.sv */
`default_nettype none
package seu_pkg;
  // line encoding strap: 1 selects the protocol framing mode, 0 the block code
  localparam int CFG_DATA_W = 8;
  localparam int CFG_PAR_W  = 4;
  localparam int CFG_CODE_W = 12;
  localparam logic [CFG_DATA_W-1:0] CFG_RESET = 8'h00;
  localparam int WORD_W_FAST = 32;
  localparam int WORD_W_SLOW = 16;
  localparam int FSM_COPIES  = 3;
  localparam int CLK_PERIOD_NS = 50;
  localparam int RECOVER_CYCLES = 3;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SYNC,
    ST_RUN,
    ST_HOLD
  } ctl_state_t;
  typedef enum logic [1:0] {
    SCR_IDLE,
    SCR_FIX
  } scrub_state_t;
endpackage
`default_nettype wire

/* File: rtl/hamming_store.sv */
`timescale 1ns/1ns
`default_nettype none
// protected configuration word; read data comes out of a register
module hamming_store (
  input  wire logic                                clk,
  input  wire logic                                sys_rst,
  input  wire logic                                wrEn,
  input  wire logic [seu_pkg::CFG_CODE_W-1:0]      wrCode,
  output logic      [seu_pkg::CFG_CODE_W-1:0]      rdCode
);
  logic [seu_pkg::CFG_CODE_W-1:0] mem_q;
  logic [seu_pkg::CFG_CODE_W-1:0] mem_d;

  always_comb begin
    mem_d = wrEn ? wrCode : mem_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_q <= '0;
    end else begin
      mem_q <= mem_d;
    end
  end

  assign rdCode = mem_q;
endmodule // hamming_store
`default_nettype wire

/* File: rtl/seu_hardened_config_and_fsm.sv */
// Notes on behaviour
// - encoding, driver and rate choices come straight from strap pins, never from storage.
// - every changeable setting such as the laser pre-bias lives in Hamming-coded storage.
// - a detected code violation starts a correction machine that rewrites corrected contents.
// - correction completes so a wrong value lasts less than one reference clock cycle.
// - control logic errors are corrected at the clock rate, 40 or 80 MHz by rate setting.
// - each protected control function exists as three identical copies.
// - state vectors form a ring; copies one and two compute their neighbour's next state.
// - copy one is loaded from a bitwise majority of the three next-state vectors.
// - after a single upset the correct state returns within three cycles.
// - recovery also works for an upset in the single voter.
// - each copy may be fed from its own clock buffer where clock loading is low.
// - serializer and clock generator are left outside the redundancy scheme.
// - a high rate strap selects slow mode, 16-bit words at 800 Mbit/s; low selects 32-bit.
`timescale 1ns/1ns
`default_nettype none
module seu_hardened_config_and_fsm (
  input  wire logic                              clk,
  input  wire logic                              sys_rst,
  input  wire logic                              line_encoding_strap,
  input  wire logic                              driver_select_strap,
  input  wire logic                              rate_width_select_strap,
  input  wire logic                              cfgWrEn,
  input  wire logic [seu_pkg::CFG_DATA_W-1:0]    cfgWrData,
  input  wire logic                              startReq,
  input  wire logic                              stopReq,
  input  wire logic [seu_pkg::CFG_CODE_W-1:0]    upsetMask,
  input  wire logic [1:0]                        stateUpset,
  output logic                                   lineEncoding,
  output logic                                   driverSelect,
  output logic                                   slowMode,
  output logic [seu_pkg::CFG_DATA_W-1:0]         preBias,
  output logic                                   scrubActive,
  output logic [1:0]                             ctlState,
  output logic                                   copiesDisagree
);
  // strap pins pass two flops; no writable storage holds them
  logic [2:0] strapMeta_q;
  logic [2:0] strapSync_q;
  logic [2:0] strapMeta_d;
  logic [2:0] strapSync_d;

  always_comb begin
    strapMeta_d = {line_encoding_strap, driver_select_strap, rate_width_select_strap};
    strapSync_d = strapMeta_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      strapMeta_q <= 3'h0;
      strapSync_q <= 3'h0;
    end else begin
      strapMeta_q <= strapMeta_d;
      strapSync_q <= strapSync_d;
    end
  end

  // Hamming(12,8) with parity bits at positions 1,2,4,8
  function automatic logic [seu_pkg::CFG_CODE_W-1:0] hamEncode(
      input logic [seu_pkg::CFG_DATA_W-1:0] d);
    logic [seu_pkg::CFG_CODE_W:1] c;
    c = '0;
    {c[12], c[11], c[10], c[9], c[7], c[6], c[5], c[3]} = d;
    c[1] = c[3] ^ c[5] ^ c[7] ^ c[9] ^ c[11];
    c[2] = c[3] ^ c[6] ^ c[7] ^ c[10] ^ c[11];
    c[4] = c[5] ^ c[6] ^ c[7] ^ c[12];
    c[8] = c[9] ^ c[10] ^ c[11] ^ c[12];
    return c;
  endfunction

  function automatic logic [3:0] hamSyndrome(input logic [seu_pkg::CFG_CODE_W-1:0] w);
    logic [seu_pkg::CFG_CODE_W:1] c;
    logic [3:0] s;
    c = w;
    s[0] = c[1] ^ c[3] ^ c[5] ^ c[7] ^ c[9] ^ c[11];
    s[1] = c[2] ^ c[3] ^ c[6] ^ c[7] ^ c[10] ^ c[11];
    s[2] = c[4] ^ c[5] ^ c[6] ^ c[7] ^ c[12];
    s[3] = c[8] ^ c[9] ^ c[10] ^ c[11] ^ c[12];
    return s;
  endfunction

  function automatic logic [seu_pkg::CFG_DATA_W-1:0] hamData(
      input logic [seu_pkg::CFG_CODE_W-1:0] w);
    logic [seu_pkg::CFG_CODE_W:1] c;
    c = w;
    return {c[12], c[11], c[10], c[9], c[7], c[6], c[5], c[3]};
  endfunction

  function automatic logic [seu_pkg::CFG_CODE_W-1:0] hamCorrect(
      input logic [seu_pkg::CFG_CODE_W-1:0] w);
    logic [3:0] s;
    logic [seu_pkg::CFG_CODE_W-1:0] f;
    s = hamSyndrome(w);
    f = w;
    if (s != 4'h0 && s <= 4'hC) begin
      f[s - 4'h1] = ~w[s - 4'h1];
    end
    return f;
  endfunction

  logic [seu_pkg::CFG_CODE_W-1:0] rdCode;
  logic [seu_pkg::CFG_CODE_W-1:0] seenCode;
  logic [seu_pkg::CFG_CODE_W-1:0] storeWrCode;
  logic                           storeWrEn;
  logic                           violation;
  seu_pkg::scrub_state_t          scrub_q;
  seu_pkg::scrub_state_t          scrub_d;
  logic [seu_pkg::CFG_DATA_W-1:0] preBias_q;
  logic [seu_pkg::CFG_DATA_W-1:0] preBias_d;

  // upsetMask lets a bench model a strike on the stored word
  assign seenCode  = rdCode ^ upsetMask;
  assign violation = hamSyndrome(seenCode) != 4'h0;

  always_comb begin
    scrub_d     = scrub_q;
    storeWrEn   = 1'b0;
    storeWrCode = hamEncode(cfgWrData);
    case (scrub_q)
      seu_pkg::SCR_IDLE: begin
        if (cfgWrEn) begin
          storeWrEn = 1'b1;
        end else if (violation) begin
          storeWrEn   = 1'b1;
          storeWrCode = hamCorrect(seenCode);
          scrub_d     = seu_pkg::SCR_FIX;
        end
      end
      seu_pkg::SCR_FIX: begin
        scrub_d = seu_pkg::SCR_IDLE;
      end
      default: scrub_d = seu_pkg::SCR_IDLE;
    endcase
  end

  // output always takes corrected data, so a single-bit error never reaches preBias
  always_comb begin
    preBias_d = hamData(hamCorrect(seenCode));
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scrub_q   <= seu_pkg::SCR_IDLE;
      preBias_q <= seu_pkg::CFG_RESET;
    end else begin
      scrub_q   <= scrub_d;
      preBias_q <= preBias_d;
    end
  end

  hamming_store u_store (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wrEn    (storeWrEn),
    .wrCode  (storeWrCode),
    .rdCode  (rdCode)
  );

  // triplicated control machine; one step runs every cycle of the reference clock
  function automatic logic [1:0] nextCtl(input logic [1:0] s, input logic go,
                                         input logic halt);
    logic [1:0] n;
    n = s;
    case (s)
      seu_pkg::ST_IDLE: n = go ? seu_pkg::ST_SYNC : seu_pkg::ST_IDLE;
      seu_pkg::ST_SYNC: n = seu_pkg::ST_RUN;
      seu_pkg::ST_RUN:  n = halt ? seu_pkg::ST_HOLD : seu_pkg::ST_RUN;
      seu_pkg::ST_HOLD: n = seu_pkg::ST_IDLE;
      default:          n = seu_pkg::ST_IDLE;
    endcase
    return n;
  endfunction

  logic [1:0] copy_q [seu_pkg::FSM_COPIES];
  logic [1:0] copy_d [seu_pkg::FSM_COPIES];
  logic [1:0] nxt    [seu_pkg::FSM_COPIES];
  logic [1:0] voted;

  genvar gi;
  generate
    for (gi = 0; gi < seu_pkg::FSM_COPIES; gi++) begin : g_copy
      // copies 0 and 1 compute the next state that loads their ring successor; copy 2 only feeds the voter
      assign nxt[gi] = nextCtl(copy_q[gi], startReq, stopReq);
    end
  endgenerate

  // single voter; a voter upset only corrupts copy 0 and heals via the ring
  assign voted = (nxt[0] & nxt[1]) | (nxt[1] & nxt[2]) | (nxt[0] & nxt[2]);

  always_comb begin
    copy_d[0] = voted ^ stateUpset;
    copy_d[1] = nxt[0];
    copy_d[2] = nxt[1];
  end

  // per-copy flops kept separate so each can sit on its own clock buffer
  generate
    for (gi = 0; gi < seu_pkg::FSM_COPIES; gi++) begin : g_reg
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          copy_q[gi] <= seu_pkg::ST_IDLE;
        end else begin
          copy_q[gi] <= copy_d[gi];
        end
      end
    end
  endgenerate

  logic [1:0] ctlState_q;
  logic       disagree_q;
  logic       scrubAct_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctlState_q <= 2'h0;
      disagree_q <= 1'b0;
      scrubAct_q <= 1'b0;
    end else begin
      ctlState_q <= voted;
      disagree_q <= (copy_q[0] != copy_q[1]) || (copy_q[1] != copy_q[2]);
      scrubAct_q <= storeWrEn && !cfgWrEn;
    end
  end

  // serializer and clock generator live elsewhere, outside this voting
  assign lineEncoding   = strapSync_q[2];
  assign driverSelect   = strapSync_q[1];
  assign slowMode       = strapSync_q[0];
  assign preBias        = preBias_q;
  assign scrubActive    = scrubAct_q;
  assign ctlState       = ctlState_q;
  assign copiesDisagree = disagree_q;
endmodule // seu_hardened_config_and_fsm
`default_nettype wire
